// ### verilog/bdo_top.sv
// bi-phase mark digital audio output with apb control
// Behaviour
// R01 - hold bit in control register forces the line output low
// R02 - each 32-bit subframe sent in bi-phase mark code
// R03 - blocks of 384 subframes, structure restarts after the last one
// R04 - positions 0 to 3 carry a code-violating four-bit preamble, no data
// R05 - block-start, left and right preambles distinguish subframe kinds
// R06 - positions 4 to 7 zero, position 4 carries flags when enabled
// R07 - sample lsb at position 12, msb at 27, positions 8 to 11 zero
// R08 - left subframe then right subframe, alternating
// R09 - position 28 one for uncorrectable samples, even if concealed
// R10 - subcode bits sent serially in position 29, block-unaligned
// R11 - same channel status bit in left and right, 192 per block
// R12 - position 31 makes positions 4 to 31 even parity
// R13 - channel status bits 0 to 3 copy the checked q control bits
// R14 - category bit 8 set, other listed status bits zero
// R15 - status bits 28 and 29 follow the programmed clock accuracy
// R16 - one left/right pair per 44.1 kHz sample period
// R17 - half-cell tick at 128 fs, invert each cell and mid-cell for ones
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bdo_defs.svh"

module bdo_top #(
	parameter int CLK_HZ    = `BDO_CLK_HZ,
	parameter int SAMPLE_HZ = `BDO_SAMPLE_HZ
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire bdo_pkg::bdo_apb_in_type  apb_in,
	output      bdo_pkg::bdo_apb_out_type apb_out,
	input  wire bdo_pkg::bdo_sample_type  sample_in,
	input  wire logic                     subcode_bit,
	input  wire logic [3:0]               q_control,
	output      logic                     sample_take,
	output      logic                     subcode_take,
	output      logic                     biphase_line_out
);
	import bdo_pkg::*;

	localparam logic [31:0] TICK_INC = 32'(SAMPLE_HZ * `BDO_HALVES_PER_FS);
	localparam logic [31:0] CLK_MOD  = 32'(CLK_HZ);

	// the half-cell rate must not exceed the clock
	if (CLK_HZ < SAMPLE_HZ * `BDO_HALVES_PER_FS || SAMPLE_HZ < 1)
	begin : g_bad_rate
		$error("bdo_top: clock too slow for the half-cell rate");
	end

	// preamble pattern for the subframe kind
	function automatic logic [7:0] pre_pat(input logic chan, input logic [7:0] frame);
		if (chan)
			pre_pat = `BDO_PRE_W; // R05
		else if (frame == `BDO_FRAME_FIRST)
			pre_pat = `BDO_PRE_B; // R05
		else
			pre_pat = `BDO_PRE_M; // R05
	endfunction : pre_pat

	// accuracy level to its {bit28, bit29} pattern
	function automatic logic [1:0] acc_pat(input logic [1:0] lvl);
		unique case (lvl)
			`BDO_ACC_LVL1: acc_pat = `BDO_ACC_PAT1; // R15
			`BDO_ACC_LVL3: acc_pat = `BDO_ACC_PAT3; // R15
			default:       acc_pat = `BDO_ACC_PAT2; // R15
		endcase
	endfunction : acc_pat

	// channel status bit for a frame of the block
	function automatic logic cs_bit(input logic [7:0] frame, input logic [3:0] qctl,
		input logic [1:0] lvl);
		logic [1:0] pat;
		pat = acc_pat(lvl);
		if (frame <= `BDO_CS_Q_LAST)
			cs_bit = qctl[frame[1:0]]; // R13
		else if (frame == `BDO_CS_CATEGORY)
			cs_bit = 1'b1; // R14
		else if (frame == `BDO_CS_ACC_A)
			cs_bit = pat[1]; // R15
		else if (frame == `BDO_CS_ACC_B)
			cs_bit = pat[0]; // R15
		else
			cs_bit = 1'b0; // R14
	endfunction : cs_bit

	bdo_state_type  s_q;
	bdo_state_type  s_d;
	logic [31:0]    acc_sum;
	logic           tick;
	logic [5:0]     nh;
	logic           nchan;
	logic [7:0]     nframe;
	logic           start;
	logic           phase_n;
	logic [31:0]    word_n;
	bdo_sample_type samp_n;
	logic [3:0]     qctl_n;
	logic [7:0]     pat;
	logic           line_n;
	logic           setup;
	logic           access;
	logic           hit_ctrl;
	logic           hit_stat;

	assign apb_out          = s_q.apb;
	assign sample_take      = s_q.samp_take;
	assign subcode_take     = s_q.sub_take;
	assign biphase_line_out = s_q.out_line;

	// next state of the whole block
	always_comb
	begin
		s_d           = s_q;
		s_d.samp_take = 1'b0;
		s_d.sub_take  = 1'b0;
		acc_sum       = s_q.acc + TICK_INC;
		tick          = 1'b0;
		nh            = s_q.half + 6'h01;
		nchan         = s_q.chan;
		nframe        = s_q.frame;
		start         = 1'b0;
		phase_n       = s_q.phase;
		word_n        = s_q.word;
		samp_n        = s_q.samp;
		qctl_n        = s_q.qctl;
		pat           = 8'h00;
		line_n        = s_q.line;

		// half-cell tick generator, averages 128 fs
		if (!s_q.ctrl.enable)
		begin
			s_d.acc   = 32'h0000_0000;
			s_d.half  = `BDO_HALF_LAST;
			s_d.chan  = 1'b1;
			s_d.frame = `BDO_FRAME_LAST;
			s_d.line  = 1'b0;
			s_d.phase = 1'b0;
		end
		else if (acc_sum >= CLK_MOD)
		begin
			s_d.acc = acc_sum - CLK_MOD; // R16
			tick    = 1'b1; // R17
		end
		else
		begin
			s_d.acc = acc_sum;
		end

		// advance the position and build the line level
		if (tick)
		begin
			if (s_q.half == `BDO_HALF_LAST)
			begin
				nchan = ~s_q.chan; // R08
				if (s_q.chan)
					nframe = (s_q.frame == `BDO_FRAME_LAST) ? `BDO_FRAME_FIRST
						: s_q.frame + 8'h01; // R03
			end
			start   = (nh == 6'h00);
			phase_n = start ? s_q.line : s_q.phase;

			// take a new pair at each left subframe
			if (start && !nchan)
			begin
				samp_n        = sample_in; // R16
				s_d.samp_take = 1'b1;
			end
			if (start && !nchan && nframe == `BDO_FRAME_FIRST)
				qctl_n = q_control; // R13

			// assemble the subframe at its first half-cell
			if (start)
			begin
				s_d.sub_take = 1'b1; // R10
				word_n = 32'h0000_0000; // R06 R07
				if (s_q.ctrl.err_flag_en)
					word_n[`BDO_POS_FLAG] = nchan ? samp_n.right_flag
						: samp_n.left_flag; // R06
				word_n[`BDO_POS_MSB:`BDO_POS_LSB] = nchan ? samp_n.right
					: samp_n.left; // R07
				word_n[`BDO_POS_VALID] = nchan ? samp_n.right_bad
					: samp_n.left_bad; // R09
				word_n[`BDO_POS_USER] = subcode_bit; // R10
				word_n[`BDO_POS_CS] = cs_bit(nframe, qctl_n,
					s_q.ctrl.accuracy); // R11
				word_n[`BDO_POS_PARITY] =
					^word_n[`BDO_POS_CS:`BDO_POS_PAR_LO]; // R12
			end

			// preamble violates the code, data cells follow the mark rule
			if (nh < `BDO_PRE_HALVES)
			begin
				pat    = pre_pat(nchan, nframe);
				line_n = pat[~nh[2:0]] ^ phase_n; // R04
			end
			else if (!nh[0])
				line_n = ~s_q.line; // R02 R17
			else
				line_n = word_n[nh[5:1]] ? ~s_q.line : s_q.line; // R02 R17

			s_d.half  = nh;
			s_d.chan  = nchan;
			s_d.frame = nframe;
			s_d.phase = phase_n;
			s_d.word  = word_n;
			s_d.samp  = samp_n;
			s_d.qctl  = qctl_n;
			s_d.line  = line_n;
		end

		// pin driver with the hold-low option
		s_d.out_line = (s_d.ctrl.hold_low || !s_q.ctrl.enable) ? 1'b0
			: s_d.line; // R01

		// apb decode
		setup    = apb_in.psel && !apb_in.penable;
		access   = apb_in.psel && apb_in.penable && s_q.apb.pready;
		hit_ctrl = (apb_in.paddr == `BDO_OFS_CTRL);
		hit_stat = (apb_in.paddr == `BDO_OFS_STATUS);

		// answer in the cycle after setup
		s_d.apb.pready  = setup;
		s_d.apb.pslverr = setup && !hit_ctrl && !(hit_stat && !apb_in.pwrite);
		s_d.apb.prdata  = 32'h0000_0000; // read data stands only in the access cycle
		if (setup && !apb_in.pwrite)
		begin
			if (hit_ctrl)
			begin
				s_d.apb.prdata[`BDO_CTRL_EN]   = s_q.ctrl.enable;
				s_d.apb.prdata[`BDO_CTRL_HOLD] = s_q.ctrl.hold_low;
				s_d.apb.prdata[`BDO_CTRL_ERRF] = s_q.ctrl.err_flag_en;
				s_d.apb.prdata[`BDO_CTRL_ACC_HI:`BDO_CTRL_ACC_LO] = s_q.ctrl.accuracy;
			end
			else if (hit_stat)
			begin
				s_d.apb.prdata[`BDO_STAT_FRAME_HI:0] = s_q.frame;
				s_d.apb.prdata[`BDO_STAT_CHAN]       = s_q.chan;
				s_d.apb.prdata[`BDO_STAT_EN]         = s_q.ctrl.enable;
			end
		end

		// control write at the completing edge
		if (access && apb_in.pwrite && hit_ctrl)
		begin
			s_d.ctrl.enable      = apb_in.pwdata[`BDO_CTRL_EN];
			s_d.ctrl.hold_low    = apb_in.pwdata[`BDO_CTRL_HOLD]; // R01
			s_d.ctrl.err_flag_en = apb_in.pwdata[`BDO_CTRL_ERRF]; // R06
			s_d.ctrl.accuracy    =
				apb_in.pwdata[`BDO_CTRL_ACC_HI:`BDO_CTRL_ACC_LO]; // R15
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q       <= '0;
			s_q.half  <= `BDO_HALF_LAST;
			s_q.chan  <= 1'b1;
			s_q.frame <= `BDO_FRAME_LAST;
			s_q.ctrl  <= bdo_ctrl_type'(`BDO_CTRL_RST);
		end
		else
		begin
			s_q <= s_d;
		end
	end

endmodule : bdo_top

// ### verilog/bdo_defs.svh
// constants for the bi-phase digital audio transmitter
`ifndef BDO_DEFS_SVH
`define BDO_DEFS_SVH

// register byte offsets
`define BDO_OFS_CTRL       12'h000
`define BDO_OFS_STATUS     12'h004

// control register fields
`define BDO_CTRL_EN        0
`define BDO_CTRL_HOLD      1
`define BDO_CTRL_ERRF      2
`define BDO_CTRL_ACC_LO    4
`define BDO_CTRL_ACC_HI    5
`define BDO_CTRL_RST       32'h0000_0000

// status register fields
`define BDO_STAT_FRAME_HI  7
`define BDO_STAT_CHAN      8
`define BDO_STAT_EN        9

// timing
`define BDO_CLK_HZ         10000000
`define BDO_SAMPLE_HZ      44100
`define BDO_HALVES_PER_FS  128

// subframe and block geometry
`define BDO_HALF_LAST      6'h3F
`define BDO_PRE_HALVES     6'h08
`define BDO_FRAME_LAST     8'hBF
`define BDO_FRAME_FIRST    8'h00

// preamble half-cell patterns, first half-cell in the msb
`define BDO_PRE_B          8'hE8
`define BDO_PRE_M          8'hE2
`define BDO_PRE_W          8'hE4

// subframe bit positions
`define BDO_POS_FLAG       4
`define BDO_POS_LSB        12
`define BDO_POS_MSB        27
`define BDO_POS_VALID      28
`define BDO_POS_USER       29
`define BDO_POS_CS         30
`define BDO_POS_PARITY     31
`define BDO_POS_PAR_LO     4

// channel status bit indices
`define BDO_CS_Q_LAST      8'h03
`define BDO_CS_CATEGORY    8'h08
`define BDO_CS_ACC_A       8'h1C
`define BDO_CS_ACC_B       8'h1D

// clock accuracy levels and their patterns {bit28, bit29}
`define BDO_ACC_LVL1       2'h0
`define BDO_ACC_LVL2       2'h1
`define BDO_ACC_LVL3       2'h2
`define BDO_ACC_PAT1       2'h2
`define BDO_ACC_PAT2       2'h0
`define BDO_ACC_PAT3       2'h1

`endif

// ### verilog/bdo_pkg.sv
// types for the bi-phase digital audio transmitter
package bdo_pkg;

	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} bdo_apb_in_type;

	// apb answer to the master
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} bdo_apb_out_type;

	// one stereo sample pair with its flags
	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
		logic        left_bad;
		logic        right_bad;
		logic        left_flag;
		logic        right_flag;
	} bdo_sample_type;

	// software control
	typedef struct packed {
		logic [1:0] accuracy;
		logic       err_flag_en;
		logic       hold_low;
		logic       enable;
	} bdo_ctrl_type;

	// complete module state
	typedef struct packed {
		logic [31:0]     acc;
		logic [5:0]      half;
		logic            chan;
		logic [7:0]      frame;
		logic [31:0]     word;
		logic            line;
		logic            phase;
		logic            out_line;
		bdo_sample_type  samp;
		logic [3:0]      qctl;
		bdo_ctrl_type    ctrl;
		bdo_apb_out_type apb;
		logic            samp_take;
		logic            sub_take;
	} bdo_state_type;

endpackage : bdo_pkg

// ### testbench/bdo_top_asserts.sv
// port checker for the bi-phase audio transmitter
`timescale 1ns/1ps

module bdo_top_asserts (
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire bdo_pkg::bdo_apb_in_type  apb_in,
	input wire bdo_pkg::bdo_apb_out_type apb_out,
	input wire logic                     sample_take,
	input wire logic                     subcode_take,
	input wire logic                     biphase_line_out
);
	import bdo_pkg::*;
	logic [1:0] ctrl_q;
	logic [3:0] since_q;
	logic [3:0] run_q;
	logic       line_q;
	logic       wr;
	// control write seen at the access edge
	assign wr = apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite
		&& apb_in.paddr == 12'h000;
	// enable and hold shadow, time since a write, length of the line level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q  <= 2'h0;
			since_q <= 4'h0;
			run_q   <= 4'h0;
			line_q  <= 1'b0;
		end
		else
		begin
			if (wr)
				ctrl_q <= apb_in.pwdata[1:0];
			since_q <= wr ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
			run_q   <= biphase_line_out != line_q ? 4'h1 : run_q + {3'h0, run_q != 4'hF};
			line_q  <= biphase_line_out;
		end
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		apb_in.psel && !apb_in.penable;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> apb_out.pready)
		else $error("pready missing after setup");
	a_ready_needs_setup: assert property
		(!(apb_in.psel && !apb_in.penable) |=> !apb_out.pready)
		else $error("pready without setup");
	a_rdata_idle_zero: assert property
		(!apb_out.pready |-> apb_out.prdata == 32'h0 && !apb_out.pslverr)
		else $error("answer outside access");
	a_unmapped_err: assert property
		(s_setup ##0 (apb_in.paddr != 12'h000 && apb_in.paddr != 12'h004)
		|=> apb_out.pslverr && apb_out.prdata == 32'h0)
		else $error("unmapped access not refused");
	a_status_wr_err: assert property
		(s_setup ##0 (apb_in.pwrite && apb_in.paddr == 12'h004) |=> apb_out.pslverr)
		else $error("status write not refused");
	a_take_pairing: assert property (sample_take |-> subcode_take)
		else $error("sample taken without subcode");
	a_line_held_low: assert property
		(ctrl_q != 2'h1 && since_q > 4'h2 |-> !biphase_line_out)
		else $error("line not low");
	a_line_run_bound: assert property
		(ctrl_q == 2'h1 && since_q > 4'hB |-> run_q < 4'h7)
		else $error("line level too long");
endmodule : bdo_top_asserts

bind bdo_top bdo_top_asserts u_bdo_top_asserts (
	.pclk(pclk), .presetn(presetn), .apb_in(apb_in), .apb_out(apb_out),
	.sample_take(sample_take), .subcode_take(subcode_take),
	.biphase_line_out(biphase_line_out)
);

// ### testbench/bdo_rx_model.sv
// receiver model that decodes the bi-phase line into subframes
`timescale 1ns/1ps
`include "bdo_defs.svh"

module bdo_rx_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        line,
	output      logic        rx_valid,
	output      logic [31:0] rx_word,
	output      logic [1:0]  rx_kind,
	output      int          viol_cnt
);
	logic        prev;
	logic        pos;
	logic [55:0] sr;
	logic [55:0] nsr;
	logic [5:0]  cnt;
	int          p;
	// half-cell recovery, preamble search and bit decode
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev     <= 1'b0;
			pos      <= 1'b0;
			sr       <= '0;
			cnt      <= 6'h3F;
			rx_valid <= 1'b0;
			rx_word  <= 32'h0;
			rx_kind  <= 2'h0;
			viol_cnt <= 0;
		end
		else
		begin
			rx_valid <= 1'b0;
			prev     <= line;
			pos      <= line != prev || !pos;
			if (line != prev || !pos)
			begin
				nsr = {sr[54:0], line};
				sr <= nsr;
				if (nsr[7:0] == `BDO_PRE_B || nsr[7:0] == ~`BDO_PRE_B)
				begin
					cnt     <= 6'h0;
					rx_kind <= 2'h0;
				end
				else if (nsr[7:0] == `BDO_PRE_M || nsr[7:0] == ~`BDO_PRE_M)
				begin
					cnt     <= 6'h0;
					rx_kind <= 2'h1;
				end
				else if (nsr[7:0] == `BDO_PRE_W || nsr[7:0] == ~`BDO_PRE_W)
				begin
					cnt     <= 6'h0;
					rx_kind <= 2'h2;
				end
				else if (cnt < 6'h38)
				begin
					if (!cnt[0] && line == sr[0])
						viol_cnt <= viol_cnt + 1;
					if (cnt == 6'h37)
					begin
						for (p = 4; p < 32; p++)
							rx_word[p] <= nsr[63 - 2 * p] ^ nsr[62 - 2 * p];
						rx_valid <= 1'b1;
					end
					cnt <= cnt + 6'h1;
				end
			end
		end
	end
endmodule : bdo_rx_model

// ### testbench/tb_top.sv
// bench for the bi-phase audio transmitter with a decoding receiver
`timescale 1ns/1ps
`include "bdo_defs.svh"

module tb_top;
	import bdo_pkg::*;
	localparam logic [11:0] CT = `BDO_OFS_CTRL;
	localparam logic [11:0] ST = `BDO_OFS_STATUS;
	localparam logic [15:0] LS = 16'hA5C3;
	localparam logic [15:0] RS = 16'h3C0F;
	localparam logic [3:0]  QC = 4'hB;
	logic            pclk;
	logic            presetn;
	bdo_apb_in_type  apb_in;
	bdo_apb_out_type apb_out;
	bdo_sample_type  sample_in;
	logic            subcode_bit;
	logic            sample_take;
	logic            subcode_take;
	logic            line;
	logic            rx_valid;
	logic [31:0]     rx_word;
	logic [1:0]      rx_kind;
	int              viol_cnt;
	int              error_cnt;
	int              n_compared;
	int              k;
	logic [31:0]     rd;
	logic            err;
	logic            seen;
	logic            sub_q[$];

	// two half-cell ticks every four clocks
	bdo_top #(.CLK_HZ(1280000), .SAMPLE_HZ(5000)) u_bdo_top (
		.pclk(pclk), .presetn(presetn), .apb_in(apb_in), .apb_out(apb_out),
		.sample_in(sample_in), .subcode_bit(subcode_bit), .q_control(QC),
		.sample_take(sample_take), .subcode_take(subcode_take), .biphase_line_out(line));
	bdo_rx_model u_bdo_rx_model (.pclk(pclk), .presetn(presetn), .line(line),
		.rx_valid(rx_valid), .rx_word(rx_word), .rx_kind(rx_kind), .viol_cnt(viol_cnt));

	// clock
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task finish_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_in.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (apb_out.pready !== 1'b1 && n < 20);
		rd = apb_out.prdata;
		err = apb_out.pslverr;
		if (apb_out.pready !== 1'b1)
		begin
			error_cnt++;
			finish_test();
		end
		apb_in.psel    <= 1'b0;
		apb_in.penable <= 1'b0;
	endtask : xfer

	function automatic logic [31:0] exp_word(input int n, input logic ub);
		logic [31:0] w;
		int          f;
		w = 32'h0;
		f = (n / 2) % 192;
		w[4] = n % 2 == 0;
		w[27:12] = n % 2 ? RS : LS;
		w[28] = n % 2 == 0;
		w[29] = ub;
		w[30] = f < 4 ? QC[f] : f == 8 || f == 29;
		w[31] = ^w[30:4];
		return w;
	endfunction : exp_word

	// subcode bit changes after each capture
	always @(posedge pclk)
	begin
		if (subcode_take === 1'b1)
		begin
			sub_q.push_back(subcode_bit);
			subcode_bit <= ~subcode_bit;
		end
	end

	// each decoded subframe against its expected kind and content
	always @(posedge pclk)
	begin
		if (rx_valid === 1'b1 && k < 400)
		begin
			check("kind", {30'h0, rx_kind}, k % 384 == 0 ? 0 : k % 2 ? 2 : 1);
			check("word", rx_word, exp_word(k, sub_q.pop_front()));
			k++;
		end
	end

	// registers, stream over a block boundary, then hold
	initial
	begin
		presetn = 1'b0;
		apb_in = '0;
		sample_in = '{LS, RS, 1'b1, 1'b0, 1'b1, 1'b0};
		subcode_bit = 1'b0;
		k = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, CT, 32'h0);
		check("ctrl reset", rd, 32'h0);
		xfer(1'b1, CT, 32'h0000_0036);
		xfer(1'b0, CT, 32'h0);
		check("ctrl", rd, 32'h0000_0036);
		xfer(1'b1, ST, 32'hFFFF_FFFF);
		check("status write", {31'h0, err}, 32'h1);
		xfer(1'b0, 12'h010, 32'h0);
		check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
		$display("registers done");
		xfer(1'b1, CT, 32'h0000_0025);
		xfer(1'b0, ST, 32'h0);
		check("status enable", rd & 32'h0000_0200, 32'h0000_0200);
		for (int i = 0; i < 60000 && k < 400; i++)
			@(posedge pclk);
		check("subframes", k, 400);
		check("coding faults", viol_cnt, 0);
		$display("stream done");
		xfer(1'b1, CT, 32'h0000_0027);
		repeat (4) @(posedge pclk);
		seen = 1'b0;
		repeat (40) @(negedge pclk) seen |= line;
		check("held line", {31'h0, seen}, 32'h0);
		xfer(1'b1, CT, 32'h0);
		$display("hold done");
		finish_test();
	end
endmodule : tb_top
